// ==== verilog/uas_pkg.sv ====
/*
  Package of the asynchronous schedule walker: register offsets, field positions,
  reset values and walker states.
  Assumes a 32-bit AHB-Lite register bus and 32-byte aligned queue heads.
*/
`default_nettype none

package uas_pkg;

  // Register byte offsets
  localparam logic [3:0] UAS_OFS_CMD     = 4'h0;
  localparam logic [3:0] UAS_OFS_STATUS  = 4'h4;
  localparam logic [3:0] UAS_OFS_IRQ_EN  = 4'h8;
  localparam logic [3:0] UAS_OFS_POINTER = 4'hC;

  // host_command_reg fields
  localparam int UAS_CMD_ENABLE_BIT   = 0;
  localparam int UAS_CMD_DOORBELL_BIT = 1;
  // host_status_reg fields
  localparam int UAS_STS_DONE_BIT     = 0;
  localparam int UAS_STS_RECLAIM_BIT  = 1;
  localparam int UAS_STS_ASYNC_BIT    = 2;
  // host_irq_enable_reg fields
  localparam int UAS_IRQ_ADVANCE_BIT  = 0;

  // Queue heads are 32-byte aligned
  localparam logic [31:0] UAS_PTR_MASK    = 32'hFFFF_FFE0;
  localparam logic [31:0] UAS_PTR_RESET   = 32'h0000_0000;
  localparam logic [31:0] UAS_WORD_RESET  = 32'h0000_0000;
  localparam logic [1:0]  UAS_HEAD_PASSES = 2'h2;
  localparam logic [1:0]  UAS_HTRANS_NSEQ = 2'h2;
  localparam logic [1:0]  UAS_HTRANS_SEQ  = 2'h3;

  typedef enum logic [3:0] {
    UAS_IDLE  = 4'b0001,
    UAS_FETCH = 4'b0010,
    UAS_EXEC  = 4'b0100,
    UAS_NEXT  = 4'b1000
  } uas_state_t;

endpackage

`default_nettype wire

// ==== verilog/uas_flag.sv ====
/*
  Sticky flag: a set pulse wins over a clear pulse in the same cycle.
  Assumes set and clear come from logic on the same clock.
*/
`default_nettype none

module uas_flag
  import uas_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic ce_in,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_out
);

  typedef struct packed {
    logic flag;
  } uas_flag_s_t;

  uas_flag_s_t r;
  uas_flag_s_t next_r;

  always_comb begin
    next_r = r;
    if (set_in) begin
      next_r.flag = 1'b1;
    end else if (clr_in) begin
      next_r.flag = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= next_r;
    end
  end

  assign flag_out = r.flag;

endmodule

`default_nettype wire

// ==== verilog/uas_walker.sv ====
/*
  Asynchronous schedule walker: AHB-Lite register slave, queue head fetch
  state machine, reclaim-based empty detection and async-advance doorbell.
  Assumes a memory reader that returns a queue head's link word, head mark
  and active bit, and a transaction engine, both on SYS_CLK_IN.
*/
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
// Overview of operation
// - No schedule fetch while the enable is not accepted.
// - A changed enable is sampled only where the pointer would be used.
// - Status follows the accepted enable: updated at start events and at microframe-end or disable pass ends, kept at empty-list stops and while idle.
// - A pass fetches the pointed queue head, executes, follows horizontal links.
// - At pass end the last horizontal link is stored into the pointer.
// - A pass ends on microframe end, empty list or cleared enable.
// - On release of cached state: set done flag and clear doorbell together.
// - Interrupt asserts while done flag and its enable are both set.
// - Doorbell completes after passing the list head twice or leaving the pass.
// - Reclaim flag set on start and transactions, cleared on marked head.
// - Marked head fetched with reclaim clear means empty list: stop.
`default_nettype none

module uas_walker
  import uas_pkg::*;
(
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        CE_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  output logic [31:0]      HRDATA_OUT,
  input  wire logic        ASYNC_START_IN,
  input  wire logic        UFRAME_END_IN,
  output logic             MEM_REQ_OUT,
  output logic [31:0]      MEM_ADDR_OUT,
  input  wire logic        MEM_ACK_IN,
  input  wire logic [31:0] QH_LINK_IN,
  input  wire logic        QH_HEAD_MARK_IN,
  input  wire logic        QH_ACTIVE_IN,
  output logic             XACT_REQ_OUT,
  input  wire logic        XACT_DONE_IN,
  output logic             IRQ_OUT
);

  typedef struct packed {
    uas_state_t  state;
    logic [31:0] list_ptr;
    logic [31:0] cur_ptr;
    logic [31:0] last_link;
    logic        enable;
    logic        status;
    logic        irq_en;
    logic        reclaim;
    logic        uframe_end;
    logic [1:0]  head_seen;
    logic        db_track;
    logic        db_done;
    logic        mem_req;
    logic        xact_req;
    logic        ahb_wr;
    logic [3:0]  ahb_addr;
    logic [31:0] rdata;
  } uas_walk_s_t;

  uas_walk_s_t r;
  uas_walk_s_t next_r;

  logic done_flag;
  logic doorbell;
  logic ahb_take;
  logic wr_cmd;
  logic wr_status;
  logic fetch_ack;
  logic pass_end;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign ahb_take  = HSEL_IN && HREADY_IN && CE_IN &&
                     (HTRANS_IN == UAS_HTRANS_NSEQ || HTRANS_IN == UAS_HTRANS_SEQ);
  assign wr_cmd    = r.ahb_wr && (r.ahb_addr == UAS_OFS_CMD);
  assign wr_status = r.ahb_wr && (r.ahb_addr == UAS_OFS_STATUS);
  assign fetch_ack = (r.state == UAS_FETCH) && MEM_ACK_IN;
  // Microframe end or disable closes the pass at the next link use
  assign pass_end  = (r.state == UAS_NEXT) && (!r.enable || r.uframe_end);

  // Done flag: hardware set wins over a write-one acknowledge
  uas_flag u_done_flag (
    .clk_in     (SYS_CLK_IN),
    .reset_n_in (RESET_N_IN),
    .ce_in      (CE_IN),
    .set_in     (r.db_done),
    .clr_in     (wr_status && HWDATA_IN[UAS_STS_DONE_BIT]),
    .flag_out   (done_flag)
  );

  // Doorbell: a fresh ring from software wins over the hardware clear
  uas_flag u_doorbell (
    .clk_in     (SYS_CLK_IN),
    .reset_n_in (RESET_N_IN),
    .ce_in      (CE_IN),
    .set_in     (wr_cmd && HWDATA_IN[UAS_CMD_DOORBELL_BIT]),
    .clr_in     (r.db_done),
    .flag_out   (doorbell)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_r          = r;
    next_r.db_done  = 1'b0;
    next_r.xact_req = 1'b0;
    next_r.ahb_wr   = ahb_take && HWRITE_IN;
    if (ahb_take) begin
      next_r.ahb_addr = HADDR_IN[3:0];
    end

    // Register writes in the data phase
    if (wr_cmd) begin
      next_r.enable = HWDATA_IN[UAS_CMD_ENABLE_BIT];
    end else if (r.ahb_wr && r.ahb_addr == UAS_OFS_IRQ_EN) begin
      next_r.irq_en = HWDATA_IN[UAS_IRQ_ADVANCE_BIT];
    end else if (r.ahb_wr && r.ahb_addr == UAS_OFS_POINTER) begin
      // Only defined while stopped; software keeps to that
      next_r.list_ptr = HWDATA_IN & UAS_PTR_MASK;
    end

    if (UFRAME_END_IN && r.state != UAS_IDLE) begin
      next_r.uframe_end = 1'b1;
    end

    case (r.state)
      UAS_IDLE: begin
        next_r.uframe_end = 1'b0;
        if (ASYNC_START_IN) begin
          next_r.status = r.enable;
          if (r.enable) begin
            next_r.reclaim = 1'b1;
            next_r.cur_ptr = r.list_ptr;
            next_r.mem_req = 1'b1;
            next_r.state   = UAS_FETCH;
          end
        end
      end
      UAS_FETCH: begin
        if (MEM_ACK_IN) begin
          next_r.mem_req   = 1'b0;
          next_r.last_link = QH_LINK_IN & UAS_PTR_MASK;
          if (QH_HEAD_MARK_IN && !r.reclaim) begin
            next_r.list_ptr = QH_LINK_IN & UAS_PTR_MASK;
            next_r.state    = UAS_IDLE;
          end else begin
            if (QH_HEAD_MARK_IN) begin
              next_r.reclaim = 1'b0;
            end
            next_r.xact_req = QH_ACTIVE_IN;
            next_r.state    = QH_ACTIVE_IN ? UAS_EXEC : UAS_NEXT;
          end
        end
      end
      UAS_EXEC: begin
        if (XACT_DONE_IN) begin
          next_r.reclaim = 1'b1;
          next_r.state   = UAS_NEXT;
        end
      end
      default: begin
        if (pass_end) begin
          next_r.list_ptr = r.last_link;
          next_r.status   = r.enable;
          next_r.state    = UAS_IDLE;
        end else begin
          next_r.cur_ptr = r.last_link;
          next_r.mem_req = 1'b1;
          next_r.state   = UAS_FETCH;
        end
      end
    endcase

    // Doorbell: note reachable state, finish after two head passes or idle
    if (doorbell && !r.db_done && !r.db_track) begin
      if (r.state == UAS_IDLE) begin
        next_r.db_done = 1'b1;
      end else begin
        next_r.db_track  = 1'b1;
        next_r.head_seen = 2'h0;
      end
    end else if (r.db_track) begin
      if (r.state == UAS_IDLE || (fetch_ack && QH_HEAD_MARK_IN &&
          r.head_seen == UAS_HEAD_PASSES - 2'h1)) begin
        next_r.db_done  = 1'b1;
        next_r.db_track = 1'b0;
      end else if (fetch_ack && QH_HEAD_MARK_IN) begin
        next_r.head_seen = r.head_seen + 2'h1;
      end
    end
    // Read data captured in the address phase, unmapped reads as zero
    next_r.rdata = UAS_WORD_RESET;
    if (ahb_take && !HWRITE_IN) begin
      if (HADDR_IN[3:0] == UAS_OFS_CMD) begin
        next_r.rdata[UAS_CMD_ENABLE_BIT]   = r.enable;
        next_r.rdata[UAS_CMD_DOORBELL_BIT] = doorbell;
      end else if (HADDR_IN[3:0] == UAS_OFS_STATUS) begin
        next_r.rdata[UAS_STS_DONE_BIT]    = done_flag;
        next_r.rdata[UAS_STS_RECLAIM_BIT] = r.reclaim;
        next_r.rdata[UAS_STS_ASYNC_BIT]   = r.status;
      end else if (HADDR_IN[3:0] == UAS_OFS_IRQ_EN) begin
        next_r.rdata[UAS_IRQ_ADVANCE_BIT] = r.irq_en;
      end else if (HADDR_IN[3:0] == UAS_OFS_POINTER) begin
        next_r.rdata = r.list_ptr;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      r          <= '0;
      r.state    <= UAS_IDLE;
      r.list_ptr <= UAS_PTR_RESET;
    end else if (CE_IN) begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Frozen clock enable inserts wait states instead of losing transfers
  assign HREADYOUT_OUT = CE_IN;
  assign HRESP_OUT     = 1'b0;
  assign HRDATA_OUT    = r.rdata;
  assign MEM_REQ_OUT   = r.mem_req;
  assign MEM_ADDR_OUT  = r.cur_ptr;
  assign XACT_REQ_OUT  = r.xact_req;
  assign IRQ_OUT       = done_flag && r.irq_en;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESET_N_IN || !CE_IN);
  chk_fetch_needs_status: assert property (
    MEM_REQ_OUT |-> r.status)
    else $error("fetch without accepted enable");
  chk_start_accepts_enable: assert property (
    (r.state == UAS_IDLE && ASYNC_START_IN && r.enable) |=> r.status && MEM_REQ_OUT)
    else $error("start did not accept enable");
  chk_first_fetch_addr: assert property (
    (r.state == UAS_IDLE && ASYNC_START_IN && r.enable) |=>
      MEM_ADDR_OUT == $past(r.list_ptr))
    else $error("first fetch not at list pointer");
  chk_pass_resume: assert property (
    pass_end |=> r.list_ptr == $past(r.last_link) && r.state == UAS_IDLE)
    else $error("pointer not retained at pass end");
  chk_disable_status: assert property (
    (r.state == UAS_NEXT && !r.enable) |=> !r.status ##1 !MEM_REQ_OUT)
    else $error("status not cleared on disable");
  chk_empty_stop: assert property (
    (fetch_ack && QH_HEAD_MARK_IN && !r.reclaim) |=> r.state == UAS_IDLE && !MEM_REQ_OUT)
    else $error("empty list not detected");
  chk_reclaim_clear: assert property (
    (fetch_ack && QH_HEAD_MARK_IN && r.reclaim) |=> !r.reclaim)
    else $error("reclaim not cleared on marked head");
  chk_done_clears_bell: assert property (
    (r.db_done && !(wr_cmd && HWDATA_IN[UAS_CMD_DOORBELL_BIT])) |=> done_flag && !doorbell)
    else $error("done and doorbell not swapped");
  chk_irq_follows: assert property (
    (r.db_done && r.irq_en && !(r.ahb_wr && r.ahb_addr == UAS_OFS_IRQ_EN)) |=> IRQ_OUT)
    else $error("interrupt missing");
  chk_ack_clears: assert property (
    (wr_status && HWDATA_IN[UAS_STS_DONE_BIT] && !r.db_done) |=> !done_flag)
    else $error("write one did not clear done flag");
  chk_uframe_stop: assert property (
    (r.state == UAS_NEXT && r.uframe_end) |=> r.state == UAS_IDLE)
    else $error("pass ran past microframe end");
  cov_full_pass: cover property (fetch_ack ##[1:20] pass_end);
  cov_empty_list: cover property (fetch_ack && QH_HEAD_MARK_IN && !r.reclaim);
  cov_doorbell: cover property (r.db_track ##[1:100] r.db_done);

endmodule

`default_nettype wire

// ==== tb/uas_mem_model.sv ====
/*
  Memory partner: three queue heads in a ring, one fetch and one transaction at a time.
  Assumes heads at 0x100, 0x120 and 0x140, all requests on the walker clock.
*/
`default_nettype none

module uas_mem_model
  import uas_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        req_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [2:0]  act_in,
  input  wire logic        xreq_in,
  output logic             ack_out,
  output logic [31:0]      link_out,
  output logic             mark_out,
  output logic             active_out,
  output logic             xdone_out,
  output logic [7:0]       fetches_out,
  output logic [7:0]       xacts_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] idx;

  initial begin
    {ack_out, link_out, mark_out, active_out, xdone_out} = '0;
    fetches_out = 8'h00;
    xacts_out   = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Alternate prompt and slow answers; lines scramble once the answer is over
  always begin
    @(posedge clk_in);
    if (req_in === 1'b1) begin
      idx = addr_in[6:5];
      repeat (fetches_out[0] ? 2'h3 : 2'h0) @(posedge clk_in);
      ack_out     <= 1'b1;
      link_out    <= (idx == 2'h2) ? 32'h0000_0100 : addr_in + 32'h0000_0020;
      mark_out    <= (idx == 2'h0);
      active_out  <= act_in[idx];
      fetches_out <= fetches_out + 8'h01;
      @(posedge clk_in);
      ack_out    <= 1'b0;
      link_out   <= ~link_out;
      mark_out   <= ~mark_out;
      active_out <= ~active_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always begin
    @(posedge clk_in);
    if (xreq_in === 1'b1) begin
      repeat (2) @(posedge clk_in);
      xdone_out <= 1'b1;
      xacts_out <= xacts_out + 8'h01;
      @(posedge clk_in);
      xdone_out <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ==== tb/uas_walker_tb.sv ====
/*
  Testbench of the schedule walker: register sequences over AHB-Lite against a ring model.
  Assumes the walker answers with zero wait states while its clock enable is high.
*/
`default_nettype none

module uas_walker_tb
  import uas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, hsel, hwrite, start, uend, hready, hresp, mreq, mack;
  logic        mark, act, xreq, xdone, irq;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rdv, maddr, link;
  logic [2:0]  act_mask;
  logic [7:0]  fetches, xacts, n;
  int          mismatches, checked;

  uas_walker u_uas_walker (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(1'b1), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwdata), .HREADY_IN(hready), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .HRDATA_OUT(hrdata), .ASYNC_START_IN(start), .UFRAME_END_IN(uend), .MEM_REQ_OUT(mreq),
    .MEM_ADDR_OUT(maddr), .MEM_ACK_IN(mack), .QH_LINK_IN(link), .QH_HEAD_MARK_IN(mark),
    .QH_ACTIVE_IN(act), .XACT_REQ_OUT(xreq), .XACT_DONE_IN(xdone), .IRQ_OUT(irq));

  uas_mem_model u_uas_mem_model (.clk_in(clk), .req_in(mreq), .addr_in(maddr),
    .act_in(act_mask), .xreq_in(xreq), .ack_out(mack), .link_out(link), .mark_out(mark),
    .active_out(act), .xdone_out(xdone), .fetches_out(fetches), .xacts_out(xacts));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [3:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= UAS_HTRANS_NSEQ;
    haddr  <= {28'h000_0000, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    chk(rdv, exp);
  endtask

  // Start event when sel is high, microframe end otherwise
  task automatic tick(input logic sel);
    if (sel) start <= 1'b1;
    else uend <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    uend  <= 1'b0;
  endtask

  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    close_out();
  end

  initial begin
    {rst_n, hsel, hwrite, start, uend, htrans, haddr, hwdata, act_mask} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(UAS_OFS_CMD, 32'h0000_0000);
    rdc(UAS_OFS_STATUS, 32'h0000_0000);
    rdc(UAS_OFS_IRQ_EN, 32'h0000_0000);
    rdc(UAS_OFS_POINTER, UAS_PTR_RESET);
    chk({30'h0000_0000, hresp, hready}, 32'h0000_0001);
    $display("test reset done");
    // Start event while disabled: no fetch
    tick(1'b1);
    repeat (20) @(posedge clk);
    chk({24'h00_0000, fetches}, 32'h0000_0000);
    rdc(UAS_OFS_STATUS, 32'h0000_0000);
    $display("test disabled done");
    // Idle ring: pass ends on empty detection
    ahb(1'b1, UAS_OFS_POINTER, 32'h0000_0100);
    ahb(1'b1, UAS_OFS_CMD, 32'h0000_0001);
    rdc(UAS_OFS_STATUS, 32'h0000_0000);
    tick(1'b1);
    repeat (60) @(posedge clk);
    rdc(UAS_OFS_STATUS, 32'h0000_0004);
    chk({24'h00_0000, fetches}, 32'h0000_0004);
    rdc(UAS_OFS_POINTER, 32'h0000_0120);
    chk(maddr, 32'h0000_0100);
    $display("test empty pass done");
    // Doorbell while idle, interrupt and acknowledge
    ahb(1'b1, UAS_OFS_IRQ_EN, 32'h0000_0001);
    ahb(1'b1, UAS_OFS_CMD, 32'h0000_0003);
    repeat (4) @(posedge clk);
    rdc(UAS_OFS_CMD, 32'h0000_0001);
    rdc(UAS_OFS_STATUS, 32'h0000_0005);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    ahb(1'b1, UAS_OFS_STATUS, 32'h0000_0000);
    rdc(UAS_OFS_STATUS, 32'h0000_0005);
    ahb(1'b1, UAS_OFS_STATUS, 32'h0000_0001);
    rdc(UAS_OFS_STATUS, 32'h0000_0004);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    $display("test doorbell idle done");
    // Busy ring: doorbell while running, then microframe end stops the pass
    act_mask <= 3'h4;
    tick(1'b1);
    repeat (40) @(posedge clk);
    ahb(1'b1, UAS_OFS_CMD, 32'h0000_0003);
    repeat (100) @(posedge clk);
    ahb(1'b0, UAS_OFS_STATUS, 32'h0000_0000);
    chk(rdv & 32'h0000_0005, 32'h0000_0005);
    rdc(UAS_OFS_CMD, 32'h0000_0001);
    ahb(1'b1, UAS_OFS_STATUS, 32'h0000_0001);
    tick(1'b0);
    repeat (60) @(posedge clk);
    n = fetches;
    repeat (40) @(posedge clk);
    chk({24'h00_0000, fetches}, {24'h00_0000, n});
    chk({31'h0000_0000, mreq}, 32'h0000_0000);
    chk({31'h0000_0000, xacts != 8'h00}, 32'h0000_0001);
    $display("test busy pass done");
    // Disable takes effect only at the next start event
    ahb(1'b1, UAS_OFS_CMD, 32'h0000_0000);
    ahb(1'b0, UAS_OFS_STATUS, 32'h0000_0000);
    chk(rdv & 32'h0000_0004, 32'h0000_0004);
    n = fetches;
    tick(1'b1);
    repeat (20) @(posedge clk);
    ahb(1'b0, UAS_OFS_STATUS, 32'h0000_0000);
    chk(rdv & 32'h0000_0004, 32'h0000_0000);
    chk({24'h00_0000, fetches}, {24'h00_0000, n});
    $display("test disable done");
    // Disable while running: pass ends at the next link use
    ahb(1'b1, UAS_OFS_CMD, 32'h0000_0001);
    tick(1'b1);
    repeat (20) @(posedge clk);
    ahb(1'b0, UAS_OFS_STATUS, 32'h0000_0000);
    chk(rdv & 32'h0000_0004, 32'h0000_0004);
    ahb(1'b1, UAS_OFS_CMD, 32'h0000_0000);
    repeat (20) @(posedge clk);
    ahb(1'b0, UAS_OFS_STATUS, 32'h0000_0000);
    chk(rdv & 32'h0000_0004, 32'h0000_0000);
    n = fetches;
    repeat (20) @(posedge clk);
    chk({24'h00_0000, fetches}, {24'h00_0000, n});
    chk({31'h0000_0000, mreq}, 32'h0000_0000);
    $display("test disable running done");
    close_out();
  end
endmodule

`default_nettype wire
